/* rtl/tcrp_pkg.sv */
// tcrp_pkg: constants and carriers for the telecommand report readout port.
// assumes: report contents come from decoder logic on the system clock.
package tcrp_pkg;

    // parallel word addresses
    localparam logic [2:0] ADDR_SEGMENT_DATA = 3'h0;
    localparam logic [2:0] ADDR_PULSE_STATUS = 3'h1;
    localparam logic [2:0] ADDR_LINK_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_SEGMENT_STATUS = 3'h3;
    localparam logic [2:0] ADDR_FRAME_FIRST = 3'h4;
    localparam logic [2:0] ADDR_FRAME_SECOND = 3'h5;
    localparam logic [2:0] ADDR_AUTH_FIRST = 3'h6;
    localparam logic [2:0] ADDR_AUTH_NEXT = 3'h7;

    // segment status word fields
    localparam int SEG_STAT_READY_BIT = 0;
    localparam int SEG_STAT_ODD_BIT = 1;

    // channel identifiers offered on the parallel port
    localparam logic [5:0] CHAN_FIRST = 6'h01;
    localparam logic [5:0] CHAN_LAST_PLAIN = 6'h3e;
    localparam logic [5:0] CHAN_AUTH = 6'h3f;

    // word counts: frame report and authentication report
    localparam logic [2:0] FRAME_WORDS = 3'h2;
    localparam logic [2:0] AUTH_WORDS = 3'h5;
    // two-sample stream on the second sample line: 2 + 5 words
    localparam logic [2:0] STREAM_LAST_WORD = 3'h6;
    localparam logic [3:0] SHIFT_LAST_BIT = 4'hf;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [2:0] PTR_RESET = 3'h0;
    localparam logic [2:0] AUTH_PTR_AFTER_FIRST = 3'h1;

    // all reports, bit numbered zero is the msb (highest index)
    typedef struct packed {
        logic [15:0] pulse_status;
        logic [15:0] link_control;
        logic [31:0] frame_report;
        logic [79:0] auth_report;
    } tcrp_reports_t;

    // one segment octet from the segmentation layer
    typedef struct packed {
        logic [5:0] channel;
        logic last;
        logic [7:0] octet;
    } tcrp_octet_t;

    typedef enum logic [1:0] {
        TCRP_PAR_IDLE = 2'b00,
        TCRP_PAR_READY = 2'b01
    } tcrp_par_state_t;

endpackage : tcrp_pkg

/* rtl/tcrp_readout_port.sv */
// tcrp_readout_port: report and segment readout, two-sample serial and parallel modes.
// assumes: pins are asynchronous to i_clock; serial pins are aligned to the shift clock.
// Summary of operation
// - two-sample mode: two sample pins plus shift clock, one serial data output
// - serial words leave msb first; bit zero is the msb
// - first sample resets stream pointer to frame report first word
// - readout: 16 pulse status, 2x16 frame report, 5x16 authentication
// - other sample pins ignored in two-sample mode, tied high on board
// - parallel select pin high enables parallel port, else serial
// - parallel mode reuses sample pins as chip select and address 2..0
// - address decode: segment, pulse, link, seg status, frame, authentication
// - repeated reads at 000 walk the segment; invalid without data ready
// - even octets on upper byte, odd octets on lower byte
// - odd segment: last octet upper, zero filler lower
// - ready raised with valid data, dropped on release in the same cycle as the bus is released
// - no ready for segment read while segment data not ready
// - segment status: bit0 data ready, bit1 odd length, rest zero
// - only channels 1..62, and 63 without authentication, are offered
// - link control word at 010, pulse status at 001, one read each
// - frame report: first half at 100, second half at 101
// - authentication: 110 gives word one, four reads at 111 the rest
// - reading 110 resets continuation pointer to the second word
// - reading second frame half sets survey status bit
// - shift clock without sample asserted gives invalid serial data
`timescale 1ns/10ps
`default_nettype none
module tcrp_readout_port (
    // system clock domain
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // report sources and segment octet feed
    input wire tcrp_pkg::tcrp_reports_t i_reports,
    input wire logic i_auth_enabled,
    input wire tcrp_pkg::tcrp_octet_t i_seg_octet,
    input wire logic i_seg_octet_valid,
    output logic o_seg_octet_ready,
    output logic o_survey_status_set,
    // configuration pins
    input wire logic i_parallel_select_pin,
    input wire logic i_sample_count_select_pin,
    // shared sample pins, active low
    input wire logic i_pulse_report_sample_n,
    input wire logic i_frame_report_sample_a_n,
    input wire logic i_frame_report_sample_b_n,
    input wire logic i_auth_report_sample_a_n,
    input wire logic i_auth_report_sample_b_n,
    // serial link
    input wire logic i_status_shift_clock_in,
    output logic o_status_serial_out,
    // parallel port
    output logic o_host_read_ready,
    output logic [15:0] o_host_read_bus,
    output logic o_host_read_bus_oe_n,
    output logic o_segment_data_ready_out
);

    // channel acceptance used by the feed and its check
    function automatic logic chan_offered(input logic [5:0] chan, input logic auth_on);
        chan_offered = (chan >= tcrp_pkg::CHAN_FIRST && chan <= tcrp_pkg::CHAN_LAST_PLAIN)
            || (chan == tcrp_pkg::CHAN_AUTH && !auth_on);
    endfunction : chan_offered

    // 16-bit slice of a report, word 0 holds the msb end
    function automatic logic [15:0] auth_word(input logic [79:0] rep, input logic [2:0] idx);
        auth_word = rep[79 - 16 * idx -: 16];
    endfunction : auth_word

    // pin synchronisers, system domain
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pin_meta <= 5'h1f;
            pin_sync <= 5'h1f;
        end else if (i_clk_en) begin
            pin_meta <= {i_parallel_select_pin, i_pulse_report_sample_n,
                i_frame_report_sample_a_n, i_frame_report_sample_b_n,
                i_auth_report_sample_a_n};
            pin_sync <= pin_meta;
        end
    end

    logic par_mode;
    logic cs_act;
    logic [2:0] addr;
    assign par_mode = pin_sync[4];
    // pins reused as select and address
    assign cs_act = par_mode && !pin_sync[3];
    assign addr = pin_sync[2:0];

    // segment word assembly
    logic [15:0] seg_word;
    logic seg_full;
    logic seg_hi_have;
    logic seg_odd;
    logic seg_accept;
    logic seg_consume;
    assign o_seg_octet_ready = !seg_full;
    assign seg_accept = i_seg_octet_valid && !seg_full;
    assign o_segment_data_ready_out = seg_full;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            seg_word <= tcrp_pkg::WORD_RESET;
            seg_full <= 1'b0;
            seg_hi_have <= 1'b0;
            seg_odd <= 1'b0;
        end else if (i_clk_en) begin
            if (seg_consume) begin
                seg_full <= 1'b0;
            end
            if (seg_accept && chan_offered(i_seg_octet.channel, i_auth_enabled)) begin
                if (!seg_hi_have) begin
                    seg_word[15:8] <= i_seg_octet.octet;
                    if (i_seg_octet.last) begin
                        seg_word[7:0] <= 8'h00;
                        seg_full <= 1'b1;
                        seg_odd <= 1'b1;
                    end else begin
                        seg_hi_have <= 1'b1;
                    end
                end else begin
                    seg_word[7:0] <= i_seg_octet.octet;
                    seg_full <= 1'b1;
                    seg_hi_have <= 1'b0;
                    if (i_seg_octet.last) begin
                        seg_odd <= 1'b0;
                    end
                end
            end
        end
    end

    // parallel read handshake
    tcrp_pkg::tcrp_par_state_t par_state;
    logic [2:0] read_addr;
    logic [2:0] auth_ptr;
    logic load;
    logic release_rd;
    // hold off segment read without data
    assign load = par_state == tcrp_pkg::TCRP_PAR_IDLE && cs_act
        && !(addr == tcrp_pkg::ADDR_SEGMENT_DATA && !seg_full);
    assign release_rd = par_state == tcrp_pkg::TCRP_PAR_READY && !cs_act;
    assign seg_consume = release_rd && read_addr == tcrp_pkg::ADDR_SEGMENT_DATA;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            par_state <= tcrp_pkg::TCRP_PAR_IDLE;
            read_addr <= tcrp_pkg::PTR_RESET;
        end else if (i_clk_en) begin
            case (par_state)
                tcrp_pkg::TCRP_PAR_IDLE: begin
                    if (load) begin
                        par_state <= tcrp_pkg::TCRP_PAR_READY;
                        read_addr <= addr;
                    end
                end
                tcrp_pkg::TCRP_PAR_READY: begin
                    // ready and bus drop on release
                    if (!cs_act) begin
                        par_state <= tcrp_pkg::TCRP_PAR_IDLE;
                    end
                end
                default: begin
                    par_state <= tcrp_pkg::TCRP_PAR_IDLE;
                end
            endcase
        end
    end

    // answer withdrawn as soon as parallel mode drops
    assign o_host_read_ready = par_state == tcrp_pkg::TCRP_PAR_READY && par_mode;
    assign o_host_read_bus_oe_n = !(par_state == tcrp_pkg::TCRP_PAR_READY && par_mode);

    // read data captured together with ready
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_host_read_bus <= tcrp_pkg::WORD_RESET;
        end else if (i_clk_en && load) begin
            case (addr)
                tcrp_pkg::ADDR_SEGMENT_DATA: o_host_read_bus <= seg_word;
                tcrp_pkg::ADDR_PULSE_STATUS: o_host_read_bus <= i_reports.pulse_status;
                tcrp_pkg::ADDR_LINK_CONTROL: o_host_read_bus <= i_reports.link_control;
                tcrp_pkg::ADDR_SEGMENT_STATUS: begin
                    o_host_read_bus <= {14'h0000, seg_odd, seg_full};
                end
                tcrp_pkg::ADDR_FRAME_FIRST: o_host_read_bus <= i_reports.frame_report[31:16];
                tcrp_pkg::ADDR_FRAME_SECOND: o_host_read_bus <= i_reports.frame_report[15:0];
                tcrp_pkg::ADDR_AUTH_FIRST: begin
                    o_host_read_bus <= auth_word(i_reports.auth_report, 3'h0);
                end
                tcrp_pkg::ADDR_AUTH_NEXT: begin
                    o_host_read_bus <= auth_word(i_reports.auth_report, auth_ptr);
                end
                default: o_host_read_bus <= tcrp_pkg::WORD_RESET;
            endcase
        end
    end

    // continuation pointer; saturates so extra reads repeat the last word
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            auth_ptr <= tcrp_pkg::AUTH_PTR_AFTER_FIRST;
        end else if (i_clk_en && load) begin
            if (addr == tcrp_pkg::ADDR_AUTH_FIRST) begin
                auth_ptr <= tcrp_pkg::AUTH_PTR_AFTER_FIRST;
            end else if (addr == tcrp_pkg::ADDR_AUTH_NEXT
                && auth_ptr != tcrp_pkg::AUTH_WORDS - 3'h1) begin
                auth_ptr <= auth_ptr + 3'h1;
            end
        end
    end

    // survey bit pulse on second half
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_survey_status_set <= 1'b0;
        end else if (i_clk_en) begin
            o_survey_status_set <= load && addr == tcrp_pkg::ADDR_FRAME_SECOND;
        end
    end

    // report snapshot handed to the link domain by a toggle handshake;
    // hold is frozen while a handover is outstanding
    tcrp_pkg::tcrp_reports_t rep_hold;
    logic req_tog;
    logic ack_meta;
    logic ack_sync;
    logic ack_tog;
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rep_hold <= '0;
            req_tog <= 1'b0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else if (i_clk_en) begin
            ack_meta <= ack_tog;
            ack_sync <= ack_meta;
            if (req_tog == ack_sync) begin
                rep_hold <= i_reports;
                req_tog <= !req_tog;
            end
        end
    end

    // link domain: reset and request synchronisers
    logic lrst_meta;
    logic link_rst;
    logic req_meta;
    logic req_sync;
    always_ff @(posedge i_status_shift_clock_in) begin
        lrst_meta <= i_sys_rst;
        link_rst <= lrst_meta;
        req_meta <= req_tog;
        req_sync <= req_meta;
    end

    tcrp_pkg::tcrp_reports_t rep_link;
    always_ff @(posedge i_status_shift_clock_in) begin
        if (link_rst) begin
            rep_link <= '0;
            ack_tog <= 1'b0;
        end else if (req_sync != ack_tog) begin
            rep_link <= rep_hold;
            ack_tog <= req_sync;
        end
    end

    // two-sample mode uses first two pins only
    logic two_sample_mode;
    logic first_act;
    logic second_act;
    logic first_prev;
    logic second_prev;
    logic [15:0] shreg;
    logic [2:0] stream_ptr;
    logic [3:0] bit_cnt;
    logic [111:0] stream;
    assign two_sample_mode = !i_parallel_select_pin && i_sample_count_select_pin;
    assign first_act = two_sample_mode && !i_pulse_report_sample_n;
    assign second_act = two_sample_mode && !i_frame_report_sample_a_n;
    // frame report then authentication on second line
    assign stream = {rep_link.frame_report, rep_link.auth_report};

    always_ff @(posedge i_status_shift_clock_in) begin
        if (link_rst) begin
            first_prev <= 1'b0;
            second_prev <= 1'b0;
            shreg <= tcrp_pkg::WORD_RESET;
            stream_ptr <= tcrp_pkg::PTR_RESET;
            bit_cnt <= 4'h0;
        end else begin
            first_prev <= first_act;
            second_prev <= second_act;
            if (first_act && !first_prev) begin
                shreg <= rep_link.pulse_status;
                stream_ptr <= tcrp_pkg::PTR_RESET;
                bit_cnt <= 4'h0;
            end else if (second_act && !second_prev) begin
                shreg <= stream[111 - 16 * stream_ptr -: 16];
                bit_cnt <= 4'h0;
                if (stream_ptr != tcrp_pkg::STREAM_LAST_WORD) begin
                    stream_ptr <= stream_ptr + 3'h1;
                end
            end else if ((first_act || second_act) && bit_cnt != tcrp_pkg::SHIFT_LAST_BIT) begin
                shreg <= {shreg[14:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    assign o_status_serial_out = shreg[15];

    property p_ready_needs_select;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && !cs_act) |=> !o_host_read_ready && o_host_read_bus_oe_n;
    endproperty
    a_ready_needs_select: assert property (p_ready_needs_select)
        else $error("ready or bus drive without chip select");

    property p_no_ready_empty_segment;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && !o_host_read_ready && cs_act && addr == tcrp_pkg::ADDR_SEGMENT_DATA
            && !seg_full) |=> !o_host_read_ready;
    endproperty
    a_no_ready_empty_segment: assert property (p_no_ready_empty_segment)
        else $error("segment read answered without data");

    property p_segment_status;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && load && addr == tcrp_pkg::ADDR_SEGMENT_STATUS) |=>
            o_host_read_bus[15:2] == 14'h0000 && o_host_read_bus[0] == $past(seg_full)
            && o_host_read_bus[1] == $past(seg_odd);
    endproperty
    a_segment_status: assert property (p_segment_status)
        else $error("segment status word wrong");

    property p_auth_rewind;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && load && addr == tcrp_pkg::ADDR_AUTH_FIRST) |=>
            auth_ptr == tcrp_pkg::AUTH_PTR_AFTER_FIRST;
    endproperty
    a_auth_rewind: assert property (p_auth_rewind)
        else $error("continuation pointer not rewound");

    property p_survey;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && load && addr == tcrp_pkg::ADDR_FRAME_SECOND) |=>
            o_survey_status_set ##1 (!i_clk_en || !o_survey_status_set);
    endproperty
    a_survey: assert property (p_survey)
        else $error("survey set not a single pulse");

    property p_odd_filler;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && seg_accept && !seg_hi_have && i_seg_octet.last
            && chan_offered(i_seg_octet.channel, i_auth_enabled)) |=>
            seg_full && seg_word == {$past(i_seg_octet.octet), 8'h00};
    endproperty
    a_odd_filler: assert property (p_odd_filler)
        else $error("odd segment word not filled");

    property p_channel_filter;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && seg_accept && !chan_offered(i_seg_octet.channel, i_auth_enabled))
            |=> $stable(seg_word) && $stable(seg_hi_have);
    endproperty
    a_channel_filter: assert property (p_channel_filter)
        else $error("octet from unoffered channel taken");

    property p_serial_no_drive;
        @(posedge i_clock) disable iff (i_sys_rst)
        !par_mode |-> o_host_read_bus_oe_n && !o_host_read_ready;
    endproperty
    a_serial_no_drive: assert property (p_serial_no_drive)
        else $error("parallel bus driven in serial mode");

    property p_first_rewinds;
        @(posedge i_status_shift_clock_in) disable iff (link_rst)
        (first_act && !first_prev) |=> stream_ptr == tcrp_pkg::PTR_RESET
            && shreg == $past(rep_link.pulse_status);
    endproperty
    a_first_rewinds: assert property (p_first_rewinds)
        else $error("first sample did not rewind stream");

    property p_shift_per_clock;
        @(posedge i_status_shift_clock_in) disable iff (link_rst)
        (first_act && first_prev && bit_cnt != tcrp_pkg::SHIFT_LAST_BIT) |=>
            shreg == {$past(shreg[14:0]), 1'b0};
    endproperty
    a_shift_per_clock: assert property (p_shift_per_clock)
        else $error("serial word did not shift");

endmodule : tcrp_readout_port
`default_nettype wire

/* testbench/tcrp_host_model.sv */
// tcrp_host_model: report reader facing the readout port pins.
// assumes: the bench calls its tasks one at a time; i_clock is the system clock.
`timescale 1ns/10ps
`default_nettype none
module tcrp_host_model (
    // system clock
    input wire logic i_clock,
    // answers from the port
    input wire logic i_ready,
    input wire logic i_oe_n,
    input wire logic [15:0] i_bus,
    input wire logic i_serial,
    // shared sample / select pins and shift clock
    output logic o_cs_n,
    output logic [2:0] o_addr,
    output logic o_shift_clk
);
    initial begin
        o_cs_n = 1'b1;
        o_addr = 3'h7;
        o_shift_clk = 1'b0;
    end
    task automatic par_read(input logic [2:0] a, input int lim, output logic [15:0] d,
        output bit got);
        got = 0;
        d = 16'h0000;
        @(posedge i_clock);
        #2;
        o_cs_n = 1'b0;
        o_addr = a;
        for (int k = 0; k < lim && !got; k++) begin
            @(posedge i_clock);
            if (i_ready === 1'b1 && i_oe_n === 1'b0) begin
                got = 1;
                d = i_bus;
            end
        end
        #2;
        o_cs_n = 1'b1;
        // released lines float: show the inverse, not the last value
        o_addr = ~a;
        repeat (5) @(posedge i_clock);
    endtask : par_read
    task automatic shift_edge;
        #80 o_shift_clk = 1'b1;
        #80 o_shift_clk = 1'b0;
    endtask : shift_edge
    task automatic ser_idle(input int n);
        o_cs_n = 1'b1;
        o_addr = 3'h7;
        repeat (n) shift_edge();
    endtask : ser_idle
    task automatic ser_word(input bit first, output logic [15:0] w);
        w = 16'h0000;
        shift_edge();
        if (first)
            o_cs_n = 1'b0;
        else
            o_addr[2] = 1'b0;
        repeat (16) begin
            shift_edge();
            w = {w[14:0], i_serial};
        end
        o_cs_n = 1'b1;
        o_addr[2] = 1'b1;
    endtask : ser_word
endmodule : tcrp_host_model
`default_nettype wire

/* testbench/tb_tc_report_readout_port.sv */
// tb_tc_report_readout_port: self-checking bench, parallel and two-sample serial reads.
// assumes: tcrp_host_model drives the pins; reports are random from a fixed lfsr.
`timescale 1ns/10ps
`default_nettype none
module tb_tc_report_readout_port;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic par_sel = 1'b1;
    logic auth_en = 1'b1;
    logic oct_valid = 1'b0;
    tcrp_pkg::tcrp_reports_t rep = '0;
    tcrp_pkg::tcrp_octet_t oct = '0;
    logic oct_ready, survey, ser, rdy, oe_n, seg_rdy, cs_n, sclk;
    logic [2:0] addr;
    logic [15:0] bus, d;
    logic [15:0] lfsr = 16'h0010;
    logic [5:0] ch;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int survey_n = 0;
    bit got;
    initial forever #12.5 i_clock = ~i_clock;
    tcrp_readout_port tcrp_readout_port_i (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1), .i_reports(rep),
        .i_auth_enabled(auth_en), .i_seg_octet(oct), .i_seg_octet_valid(oct_valid),
        .o_seg_octet_ready(oct_ready), .o_survey_status_set(survey),
        .i_parallel_select_pin(par_sel), .i_sample_count_select_pin(1'b1),
        .i_pulse_report_sample_n(cs_n), .i_frame_report_sample_a_n(addr[2]),
        .i_frame_report_sample_b_n(addr[1]), .i_auth_report_sample_a_n(addr[0]),
        .i_auth_report_sample_b_n(1'b1), .i_status_shift_clock_in(sclk),
        .o_status_serial_out(ser), .o_host_read_ready(rdy), .o_host_read_bus(bus),
        .o_host_read_bus_oe_n(oe_n), .o_segment_data_ready_out(seg_rdy));
    tcrp_host_model tcrp_host_model_i (
        .i_clock(i_clock), .i_ready(rdy), .i_oe_n(oe_n), .i_bus(bus), .i_serial(ser),
        .o_cs_n(cs_n), .o_addr(addr), .o_shift_clk(sclk));
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand
    // stream word k: frame halves then authentication words, bit zero first
    function automatic logic [15:0] stream_word(input int k);
        logic [111:0] s;
        s = {rep.frame_report, rep.auth_report};
        return s[111 - 16 * k -: 16];
    endfunction : stream_word
    task automatic rand_reports;
        for (int i = 0; i < 9; i++) begin
            lfsr = next_rand(lfsr);
            rep = {rep[127:0], lfsr};
        end
    endtask : rand_reports
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string name);
        tcrp_host_model_i.par_read(a, 40, d, got);
        check(name, d, exp);
        check("ready released", {14'h0, rdy, oe_n}, 16'h0001);
    endtask : rd
    task automatic feed(input logic [5:0] c, input logic [7:0] o, input logic last);
        @(posedge i_clock);
        #2;
        oct = '{channel: c, last: last, octet: o};
        oct_valid = 1'b1;
        for (int k = 0; k < 200; k++) begin
            @(posedge i_clock);
            if (oct_ready === 1'b1)
                break;
        end
        #2;
        oct_valid = 1'b0;
    endtask : feed
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    always @(posedge i_clock) begin
        cycles++;
        if (survey === 1'b1)
            survey_n++;
        if (cycles == 60000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        rand_reports();
        // link reset needs the shift clock running
        fork
            repeat (10) @(posedge i_clock);
            tcrp_host_model_i.ser_idle(4);
        join
        @(posedge i_clock);
        #2 i_sys_rst = 1'b0;
        repeat (4) @(posedge i_clock);
        rd(3'h1, rep.pulse_status, "pulse");
        rd(3'h2, rep.link_control, "link");
        rd(3'h4, stream_word(0), "frame1");
        rd(3'h5, stream_word(1), "frame2");
        check("survey", 16'(survey_n), 16'h0001);
        // truncated run first, then a full one after the pointer reset
        for (int r = 0; r < 2; r++) begin
            rd(3'h6, stream_word(2), "auth1");
            for (int k = 3; k < 6 + r; k++)
                rd(3'h7, stream_word(k), "auth2");
        end
        rd(3'h3, 16'h0000, "seg status idle");
        feed(6'h3f, 8'h11, 1'b1);
        feed(6'h00, 8'h22, 1'b1);
        tcrp_host_model_i.par_read(3'h0, 20, d, got);
        check("refused", {15'h0, got}, 16'h0000);
        lfsr = next_rand(lfsr);
        ch = 6'(lfsr % 62 + 1);
        fork
            begin
                feed(ch, 8'haa, 1'b0);
                feed(ch, 8'hbb, 1'b0);
                feed(ch, 8'hcc, 1'b1);
            end
            begin
                rd(3'h0, 16'haabb, "seg0");
                repeat (6) @(posedge i_clock);
                rd(3'h3, 16'h0003, "seg status odd");
                rd(3'h0, 16'hcc00, "seg1");
            end
        join
        check("seg ready", {15'h0, seg_rdy}, 16'h0000);
        #2 auth_en = 1'b0;
        fork
            feed(6'h3f, 8'h5a, 1'b1);
            rd(3'h0, 16'h5a00, "chan63");
        join
        #2 par_sel = 1'b0;
        rand_reports();
        tcrp_host_model_i.ser_idle(8);
        for (int p = 0; p < 2; p++) begin
            tcrp_host_model_i.ser_word(1, d);
            check("ser pulse", d, rep.pulse_status);
            check("no parallel answer", {15'h0, rdy}, 16'h0000);
            for (int k = 0; k < 7 - 5 * p; k++) begin
                tcrp_host_model_i.ser_word(0, d);
                check("ser stream", d, stream_word(k));
            end
        end
        end_of_test();
    end
endmodule : tb_tc_report_readout_port
`default_nettype wire
